// >>> pcsia_pkg.sv
package pcsia_pkg;

	// ==========================================
	// program addressing
	localparam int         PC_W      = 15;
	localparam int         PM_AW     = 13;
	localparam int         PM_DW     = 14;
	localparam logic [14:0] VEC_RESET = 15'h0000;
	localparam logic [14:0] VEC_IRQ   = 15'h0004;

	// ==========================================
	// return stack
	localparam int         STK_DEPTH = 16;
	localparam int         STK_CW    = 5;

	// ==========================================
	// pointers and linear view
	localparam int         PTR_PM_BIT     = 15;
	localparam logic [3:0] LIN_REGION     = 4'h2;
	localparam logic [11:0] LIN_BANK_BYTES = 12'h050;
	localparam logic [6:0] LIN_GPR_BASE   = 7'h20;

	// ==========================================
	// register byte addresses
	localparam logic [7:0] ADDR_IND0   = 8'h00;
	localparam logic [7:0] ADDR_IND1   = 8'h04;
	localparam logic [7:0] ADDR_P0LO   = 8'h08;
	localparam logic [7:0] ADDR_P0HI   = 8'h0c;
	localparam logic [7:0] ADDR_P1LO   = 8'h10;
	localparam logic [7:0] ADDR_P1HI   = 8'h14;
	localparam logic [7:0] ADDR_WREG   = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;
	localparam logic [7:0] ADDR_BSR    = 8'h20;
	localparam logic [7:0] ADDR_PCLATH = 8'h24;
	localparam logic [7:0] ADDR_POWER_CONTROL_REGISTER   = 8'h28;
	localparam logic [7:0] ADDR_CFG    = 8'h2c;
	localparam logic [7:0] ADDR_PC     = 8'h30;
	localparam logic [7:0] ADDR_DEPTH  = 8'h34;

	// ==========================================
	// field positions and reset values
	localparam int         POWER_CONTROL_REGISTER_UNF_BIT = 0;
	localparam int         POWER_CONTROL_REGISTER_OVF_BIT = 1;
	localparam int         CFG_STKR_BIT = 0;
	localparam logic       CFG_STKR_RST = 1'b1;

	// ==========================================
	// sequencer operations
	typedef enum logic [2:0] {
		OP_HOLD,
		OP_STEP,
		OP_JUMP,
		OP_CALL,
		OP_RET,
		OP_IRQ,
		OP_RETFIE
	} pcsia_op_type;

endpackage

// >>> pcsia_stack.sv
`timescale 1ns/100ps
module pcsia_stack
	import pcsia_pkg::*;
(
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// control
	input  wire logic              clear,
	input  wire logic              push,
	input  wire logic              pop,
	input  wire logic [PC_W-1:0]   push_data,
	// state
	output logic      [PC_W-1:0]   top,
	output logic      [STK_CW-1:0] depth,
	output logic                   overflow,
	output logic                   underflow
);

	logic [PC_W-1:0] mem [STK_DEPTH];
	logic            full;
	logic            empty;

	assign full  = depth == STK_CW'(STK_DEPTH);
	assign empty = depth == '0;
	assign top   = mem[4'(depth - 5'h01)];

	always_ff @(posedge hclk) begin
		if (push && !full && !clear) begin
			mem[depth[3:0]] <= push_data;
		end
	end

	// depth counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			depth <= '0;
		end else if (clear) begin
			depth <= '0;
		end else if (push && !full) begin
			depth <= depth + 5'h01;
		end else if (pop && !empty) begin
			depth <= depth - 5'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overflow  <= 1'b0;
			underflow <= 1'b0;
		end else begin
			overflow  <= push && full && !clear;
			underflow <= pop && empty && !clear;
		end
	end

endmodule

// >>> pcsia_pointer.sv
`timescale 1ns/100ps
module pcsia_pointer
	import pcsia_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// byte writes
	input  wire logic        wr_lo,
	input  wire logic        wr_hi,
	input  wire logic [7:0]  wdata,
	// shadow restore
	input  wire logic        restore,
	input  wire logic [15:0] restore_val,
	// value
	output logic      [15:0] value
);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			value <= 16'h0000;
		end else if (restore) begin
			value <= restore_val;
		end else begin
			if (wr_lo) begin
				value[7:0] <= wdata;
			end
			if (wr_hi) begin
				value[15:8] <= wdata;
			end
		end
	end

endmodule

// >>> pcsia_core.sv
`timescale 1ns/100ps
// Overview of operation
// - program counter is fifteen bits wide
// - fetches wrap into 8192 implemented words
// - reset loads 0000h, interrupt jumps 0004h
// - separate sixteen entry fifteen bit stack
// - overflow/underflow set flags, may reset
// - interrupt saves and restores core shadows
// - two sixteen bit pointers reach everything
// - program memory access adds one cycle
// - pointer high bit seven selects program
// - program read gives low eight bits
// - indirect writes never alter program memory
// - linear view of general RAM
module pcsia_core
	import pcsia_pkg::*;
(
	// clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// ahb-lite slave
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic      [31:0]        hrdata,
	// instruction sequencer
	input  wire logic               seq_valid,
	input  wire pcsia_op_type       seq_op,
	input  wire logic [PC_W-1:0]    seq_target,
	output logic      [PC_W-1:0]    pc,
	output logic                    fetch_stall,
	output logic                    soft_reset,
	// program memory
	output logic      [PM_AW-1:0]   pm_addr,
	input  wire logic [PM_DW-1:0]   pm_rdata,
	// data memory
	output logic      [11:0]        dm_addr,
	output logic                    dm_re,
	output logic                    dm_we,
	output logic      [7:0]         dm_wdata,
	input  wire logic [7:0]         dm_rdata
);

	// ==========================================
	// declarations
	logic              dp_valid;
	logic              dp_write;
	logic [7:0]        dp_addr;
	logic              ap_take;
	logic              dp_ind;
	logic              dp_pm_read;
	logic              pm_wait;
	logic              pm_steal;
	logic [PM_DW-1:0]  pm_data;
	logic              wr_done;
	logic              rd_done;
	logic [15:0]       ptr0;
	logic [15:0]       ptr1;
	logic [15:0]       sel_ptr;
	logic [7:0]        wreg;
	logic [7:0]        status;
	logic [4:0]        bsr;
	logic [6:0]        pclath;
	logic [7:0]        sh_wreg;
	logic [7:0]        sh_status;
	logic [4:0]        sh_bsr;
	logic [6:0]        sh_pclath;
	logic [15:0]       sh_ptr0;
	logic [15:0]       sh_ptr1;
	logic              stk_ovf_flag;
	logic              stk_unf_flag;
	logic              stk_reset_en;
	logic              op_call;
	logic              op_irq;
	logic              op_ret;
	logic              op_retfie;
	logic              stk_push;
	logic              stk_pop;
	logic [PC_W-1:0]   stk_top;
	logic [PC_W-1:0]   next_pc;
	logic [STK_CW-1:0] stk_depth;
	logic              stk_ovf;
	logic              stk_unf;
	logic              power_control_register_wr;

	// ==========================================
	// linear data view
	// linear gpr mapping
	function automatic logic [11:0] pcsia_map(input logic [15:0] p);
		logic [11:0] lin;
		logic [4:0]  bank;
		logic [6:0]  off;
		lin  = p[11:0];
		bank = 5'(lin / LIN_BANK_BYTES);
		off  = 7'(lin % LIN_BANK_BYTES) + LIN_GPR_BASE;
		if (p[15:12] == LIN_REGION) begin
			return {bank, off};
		end
		return p[11:0];
	endfunction

	// ==========================================
	// ahb-lite address and data phase
	assign ap_take = hsel && hready && htrans[1];
	assign hresp   = 1'b0;

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
		end else if (hready) begin
			dp_valid <= ap_take;
			dp_write <= hwrite;
			dp_addr  <= {haddr[7:2], 2'b00};
		end
	end

	assign dp_ind  = dp_addr == ADDR_IND0 || dp_addr == ADDR_IND1;
	assign sel_ptr = (dp_addr == ADDR_IND1) ? ptr1 : ptr0;

	assign dp_pm_read = dp_valid && !dp_write && dp_ind && sel_ptr[PTR_PM_BIT];

	assign pm_steal  = dp_pm_read && !pm_wait;
	assign hreadyout = !pm_steal;
	assign wr_done   = dp_valid && dp_write;
	assign rd_done   = dp_valid && !dp_write && hreadyout;

	// program read wait and capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pm_wait <= 1'b0;
			pm_data <= '0;
		end else begin
			pm_wait <= pm_steal;
			if (pm_steal) begin
				pm_data <= pm_rdata;
			end
		end
	end

	// ==========================================
	// memory ports
	// wrap into implemented space
	assign pm_addr     = pm_steal ? sel_ptr[PM_AW-1:0] : pc[PM_AW-1:0];
	assign fetch_stall = pm_steal;
	assign dm_addr     = pcsia_map(sel_ptr);
	assign dm_re       = dp_valid && !dp_write && dp_ind && !sel_ptr[PTR_PM_BIT];
	assign dm_wdata    = hwdata[7:0];
	assign dm_we       = wr_done && dp_ind && !sel_ptr[PTR_PM_BIT];

	// ==========================================
	// pointers
	// two pointer registers
	pcsia_pointer u_ptr0 (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.wr_lo       (wr_done && dp_addr == ADDR_P0LO),
		.wr_hi       (wr_done && dp_addr == ADDR_P0HI),
		.wdata       (hwdata[7:0]),
		.restore     (op_retfie),
		.restore_val (sh_ptr0),
		.value       (ptr0)
	);

	pcsia_pointer u_ptr1 (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.wr_lo       (wr_done && dp_addr == ADDR_P1LO),
		.wr_hi       (wr_done && dp_addr == ADDR_P1HI),
		.wdata       (hwdata[7:0]),
		.restore     (op_retfie),
		.restore_val (sh_ptr1),
		.value       (ptr1)
	);

	// ==========================================
	// core registers
	// working register, restore first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wreg <= 8'h00;
		end else if (op_retfie) begin
			wreg <= sh_wreg;
		end else if (wr_done && dp_addr == ADDR_WREG) begin
			wreg <= hwdata[7:0];
		end else if (rd_done && dp_ind) begin
			wreg <= sel_ptr[PTR_PM_BIT] ? pm_data[7:0] : dm_rdata;
		end
	end

	// status, bank and page latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= 8'h00;
			bsr    <= 5'h00;
			pclath <= 7'h00;
		end else if (op_retfie) begin
			status <= sh_status;
			bsr    <= sh_bsr;
			pclath <= sh_pclath;
		end else if (wr_done) begin
			if (dp_addr == ADDR_STATUS) begin
				status <= hwdata[7:0];
			end
			if (dp_addr == ADDR_BSR) begin
				bsr <= hwdata[4:0];
			end
			if (dp_addr == ADDR_PCLATH) begin
				pclath <= hwdata[6:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sh_wreg   <= 8'h00;
			sh_status <= 8'h00;
			sh_bsr    <= 5'h00;
			sh_pclath <= 7'h00;
			sh_ptr0   <= 16'h0000;
			sh_ptr1   <= 16'h0000;
		end else if (op_irq) begin
			sh_wreg   <= wreg;
			sh_status <= status;
			sh_bsr    <= bsr;
			sh_pclath <= pclath;
			sh_ptr0   <= ptr0;
			sh_ptr1   <= ptr1;
		end
	end

	// ==========================================
	// program counter and stack
	assign op_call   = seq_valid && seq_op == OP_CALL && !soft_reset;
	assign op_irq    = seq_valid && seq_op == OP_IRQ && !soft_reset;
	assign op_ret    = seq_valid && seq_op == OP_RET && !soft_reset;
	assign op_retfie = seq_valid && seq_op == OP_RETFIE && !soft_reset;

	assign stk_push = op_call || op_irq;
	assign stk_pop  = op_ret || op_retfie;

	pcsia_stack u_stack (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.clear     (soft_reset),
		.push      (stk_push),
		.pop       (stk_pop),
		.push_data (op_call ? pc + 15'h0001 : pc),
		.top       (stk_top),
		.depth     (stk_depth),
		.overflow  (stk_ovf),
		.underflow (stk_unf)
	);

	// next program counter
	always_comb begin
		next_pc = pc;
		if (seq_valid) begin
			unique case (seq_op)
				OP_HOLD: next_pc = pc;
				OP_STEP: next_pc = pc + 15'h0001;
				OP_JUMP: next_pc = seq_target;
				OP_CALL: next_pc = seq_target;
				OP_IRQ: next_pc = VEC_IRQ;
				OP_RET: next_pc = (stk_depth == '0) ? VEC_RESET : stk_top;
				OP_RETFIE: next_pc = (stk_depth == '0) ? VEC_RESET : stk_top;
				default: next_pc = pc;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc <= VEC_RESET;
		end else if (soft_reset) begin
			pc <= VEC_RESET;
		end else begin
			pc <= next_pc;
		end
	end

	// ==========================================
	// stack fault flags and reset
	assign power_control_register_wr = wr_done && dp_addr == ADDR_POWER_CONTROL_REGISTER;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stk_ovf_flag <= 1'b0;
			stk_unf_flag <= 1'b0;
		end else begin
			if (stk_ovf) begin
				stk_ovf_flag <= 1'b1;
			end else if (power_control_register_wr && !hwdata[POWER_CONTROL_REGISTER_OVF_BIT]) begin
				stk_ovf_flag <= 1'b0;
			end
			if (stk_unf) begin
				stk_unf_flag <= 1'b1;
			end else if (power_control_register_wr && !hwdata[POWER_CONTROL_REGISTER_UNF_BIT]) begin
				stk_unf_flag <= 1'b0;
			end
		end
	end

	// configuration enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stk_reset_en <= CFG_STKR_RST;
		end else if (wr_done && dp_addr == ADDR_CFG) begin
			stk_reset_en <= hwdata[CFG_STKR_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= stk_reset_en && (stk_ovf || stk_unf) && !soft_reset;
		end
	end

	// ==========================================
	// read data
	always_comb begin
		hrdata = 32'h0000_0000;
		if (dp_valid && !dp_write) begin
			case (dp_addr)
				ADDR_IND0,
				ADDR_IND1: hrdata[7:0] = sel_ptr[PTR_PM_BIT] ? pm_data[7:0] : dm_rdata;
				ADDR_P0LO: hrdata[7:0] = ptr0[7:0];
				ADDR_P0HI: hrdata[7:0] = ptr0[15:8];
				ADDR_P1LO: hrdata[7:0] = ptr1[7:0];
				ADDR_P1HI: hrdata[7:0] = ptr1[15:8];
				ADDR_WREG: hrdata[7:0] = wreg;
				ADDR_STATUS: hrdata[7:0] = status;
				ADDR_BSR: hrdata[4:0] = bsr;
				ADDR_PCLATH: hrdata[6:0] = pclath;
				ADDR_POWER_CONTROL_REGISTER: hrdata[1:0] = {stk_ovf_flag, stk_unf_flag};
				ADDR_CFG: hrdata[0] = stk_reset_en;
				ADDR_PC: hrdata[PC_W-1:0] = pc;
				ADDR_DEPTH: hrdata[STK_CW-1:0] = stk_depth;
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

endmodule

// >>> pcsia_core_props.sv
`timescale 1ns/100ps
module pcsia_core_props
	import pcsia_pkg::*;
(
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// watched outputs and inputs
	input  wire logic             hreadyout,
	input  wire logic             seq_valid,
	input  wire pcsia_op_type     seq_op,
	input  wire logic [PC_W-1:0]  seq_target,
	input  wire logic [PC_W-1:0]  pc,
	input  wire logic             fetch_stall,
	input  wire logic             soft_reset,
	input  wire logic [PM_AW-1:0] pm_addr,
	input  wire logic             dm_we
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// ==========
	// expected return address of the latest push
	logic            armed;
	logic [PC_W-1:0] ret_pc;
	logic            go;
	assign go = seq_valid && !soft_reset;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed <= 1'b0;
			ret_pc <= 15'h0000;
		end else if (go && seq_op == OP_CALL) begin
			armed <= 1'b1;
			ret_pc <= pc + 15'h0001;
		end else if (go && seq_op == OP_IRQ) begin
			armed <= 1'b1;
			ret_pc <= pc;
		end else if (soft_reset || (go && seq_op != OP_HOLD)) begin
			armed <= 1'b0;
		end
	end

	// ==========
	// properties
	property p_step;
		go && seq_op == OP_STEP |=> pc == $past(pc) + 15'h0001;
	endproperty
	a_step: assert property (p_step) else $error("pc step wrong");
	property p_wrap;
		!fetch_stall |-> pm_addr == pc[12:0];
	endproperty
	a_wrap: assert property (p_wrap) else $error("fetch address not wrapped");
	property p_irq;
		go && seq_op == OP_IRQ |=> pc == VEC_IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("irq vector wrong");
	property p_call;
		go && seq_op == OP_CALL |=> pc == $past(seq_target);
	endproperty
	a_call: assert property (p_call) else $error("call target wrong");
	property p_ret;
		go && armed && (seq_op == OP_RET || seq_op == OP_RETFIE) |=> pc == $past(ret_pc);
	endproperty
	a_ret: assert property (p_ret) else $error("return address wrong");
	property p_srst;
		soft_reset |=> pc == VEC_RESET && !soft_reset;
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
	property p_stall;
		fetch_stall |-> !hreadyout ##1 hreadyout;
	endproperty
	a_stall: assert property (p_stall) else $error("program read wait wrong");
	property p_nowe;
		fetch_stall |-> !dm_we;
	endproperty
	a_nowe: assert property (p_nowe) else $error("write during program access");

	// ==========
	// scenario coverage
	c_stall: cover property (fetch_stall);
	c_srst: cover property (soft_reset);
	c_ret: cover property (go && armed && seq_op == OP_RETFIE);
endmodule

bind pcsia_core pcsia_core_props i_pcsia_core_props (
	.hclk, .hresetn, .hreadyout, .seq_valid, .seq_op, .seq_target,
	.pc, .fetch_stall, .soft_reset, .pm_addr, .dm_we
);

// >>> pcsia_mem_model.sv
`timescale 1ns/100ps
module pcsia_mem_model
	import pcsia_pkg::*;
(
	// clock
	input  wire logic             hclk,
	// program memory port
	input  wire logic [PM_AW-1:0] pm_addr,
	output logic      [PM_DW-1:0] pm_rdata,
	// data memory port
	input  wire logic [11:0]      dm_addr,
	input  wire logic             dm_re,
	input  wire logic             dm_we,
	input  wire logic [7:0]       dm_wdata,
	output logic      [7:0]       dm_rdata
);
	logic [7:0] dmem [0:4095];

	assign pm_rdata = {pm_addr[5:0], pm_addr[7:0] ^ 8'h5a};

	always @(posedge hclk) begin
		if (dm_we === 1'b1) begin
			dmem[dm_addr] <= dm_wdata;
		end
	end
	// read data only while the core asks for it
	assign dm_rdata = (dm_re === 1'b1) ? dmem[dm_addr] : 8'h00;
endmodule

// >>> tb.sv
`timescale 1ns/100ps
module tb
	import pcsia_pkg::*;
;
	logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, seq_valid = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	pcsia_op_type seq_op = OP_HOLD;
	logic [14:0] seq_target = 0, pc;
	logic hreadyout, hresp, fetch_stall, soft_reset, dm_re, dm_we;
	logic [12:0] pm_addr;
	logic [13:0] pm_rdata;
	logic [11:0] dm_addr;
	logic [7:0] dm_wdata, dm_rdata;
	int n_errors = 0, samples_checked = 0, n_sr = 0, wt;

	pcsia_core i_pcsia_core (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .seq_valid, .seq_op, .seq_target, .pc,
		.fetch_stall, .soft_reset, .pm_addr, .pm_rdata, .dm_addr, .dm_re, .dm_we, .dm_wdata, .dm_rdata);
	pcsia_mem_model i_pcsia_mem_model (.hclk, .pm_addr, .pm_rdata, .dm_addr, .dm_re, .dm_we, .dm_wdata,
		.dm_rdata);

	// ==========
	// clock and pulse count
	always #10 hclk = ~hclk;
	always @(posedge hclk) begin
		if (soft_reset === 1'b1) begin
			n_sr <= n_sr + 1;
		end
	end

	// ==========
	// shared tasks
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk);
		while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		wt = -1;
		do begin
			@(posedge hclk);
			wt++;
		end while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, q, e);
		chk("hresp", hresp, 32'h0);
	endtask
	task op(input pcsia_op_type o, input logic [14:0] t);
		@(posedge hclk);
		seq_valid <= 1'b1;
		seq_op <= o;
		seq_target <= t;
		@(posedge hclk);
		seq_valid <= 1'b0;
		#1;
	endtask

	// ==========
	// scenarios
	task t_reset;
		chk("pc", pc, 32'h0);
		rdc(ADDR_CFG, 32'h1, "cfg");
		rdc(ADDR_POWER_CONTROL_REGISTER, 32'h0, "power_control_register");
		wr(8'h3c, 32'hff);
		rdc(8'h3c, 32'h0, "unmapped");
	endtask
	task t_flow;
		op(OP_STEP, 15'h0);
		chk("pc", pc, 32'h1);
		op(OP_JUMP, 15'h7fff);
		op(OP_STEP, 15'h0);
		chk("pc", pc, 32'h0);
		op(OP_JUMP, 15'h2005);
		chk("pm_addr", pm_addr, 32'h5);
		rdc(ADDR_PC, 32'h2005, "pc_reg");
		wr(ADDR_WREG, 32'h3c);
		wr(ADDR_P0LO, 32'h12);
		wr(ADDR_STATUS, 32'ha5);
		wr(ADDR_BSR, 32'h13);
		wr(ADDR_PCLATH, 32'h5a);
		wr(ADDR_P1LO, 32'h77);
		op(OP_IRQ, 15'h0);
		chk("pc", pc, 32'h4);
		wr(ADDR_WREG, 32'h11);
		wr(ADDR_P0LO, 32'h34);
		wr(ADDR_STATUS, 32'h00);
		wr(ADDR_BSR, 32'h00);
		wr(ADDR_PCLATH, 32'h00);
		wr(ADDR_P1LO, 32'h00);
		op(OP_RETFIE, 15'h0);
		chk("pc", pc, 32'h2005);
		rdc(ADDR_WREG, 32'h3c, "w");
		rdc(ADDR_P0LO, 32'h12, "p0lo");
		rdc(ADDR_STATUS, 32'ha5, "status");
		rdc(ADDR_BSR, 32'h13, "bsr");
		rdc(ADDR_PCLATH, 32'h5a, "pclath");
		rdc(ADDR_P1LO, 32'h77, "p1lo");
		op(OP_JUMP, 15'h7fff);
		op(OP_CALL, 15'h100);
		rdc(ADDR_DEPTH, 32'h1, "depth");
		op(OP_RET, 15'h0);
		chk("pc", pc, 32'h0);
	endtask
	task t_stack;
		for (int i = 0; i < 16; i++) begin
			op(OP_CALL, 15'h4000 + i[14:0]);
		end
		rdc(ADDR_DEPTH, 32'h10, "depth");
		op(OP_RET, 15'h0);
		chk("pc", pc, 32'h400f);
		op(OP_CALL, 15'h0);
		op(OP_CALL, 15'h55);
		repeat (4) @(posedge hclk);
		chk("n_sr", n_sr, 32'h1);
		chk("pc", pc, 32'h0);
		rdc(ADDR_POWER_CONTROL_REGISTER, 32'h2, "power_control_register");
		rdc(ADDR_DEPTH, 32'h0, "depth");
		wr(ADDR_CFG, 32'h0);
		wr(ADDR_POWER_CONTROL_REGISTER, 32'h0);
		op(OP_RET, 15'h0);
		repeat (4) @(posedge hclk);
		chk("n_sr", n_sr, 32'h1);
		rdc(ADDR_POWER_CONTROL_REGISTER, 32'h1, "power_control_register");
		wr(ADDR_CFG, 32'h1);
		op(OP_RET, 15'h0);
		repeat (4) @(posedge hclk);
		chk("n_sr", n_sr, 32'h2);
	endtask
	task t_ind;
		wr(ADDR_P1HI, 32'h0);
		wr(ADDR_P1LO, 32'h45);
		wr(ADDR_IND1, 32'ha7);
		rdc(ADDR_IND1, 32'ha7, "ind1");
		chk("wait", wt, 32'h0);
		wr(ADDR_P0HI, 32'h80);
		wr(ADDR_P0LO, 32'h45);
		wr(ADDR_IND0, 32'h99);
		rdc(ADDR_IND1, 32'ha7, "ind1");
		wr(ADDR_P0HI, 32'h81);
		wr(ADDR_P0LO, 32'h23);
		rdc(ADDR_P0HI, 32'h81, "p0hi");
		rdc(ADDR_IND0, 32'h79, "ind0");
		chk("wait", wt, 32'h1);
		rdc(ADDR_WREG, 32'h79, "w");
		wr(ADDR_P1HI, 32'h20);
		wr(ADDR_P1LO, 32'h55);
		wr(ADDR_IND1, 32'h6e);
		wr(ADDR_P1HI, 32'h0);
		wr(ADDR_P1LO, 32'ha5);
		rdc(ADDR_IND1, 32'h6e, "linear");
	endtask

	// ==========
	// verdict, main sequence, watchdog
	task print_verdict;
		if (n_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_flow;
		t_stack;
		t_ind;
		print_verdict;
	end
	initial begin
		repeat (5000) @(posedge hclk);
		n_errors++;
		print_verdict;
	end
endmodule
